// File: verilog/spc_port_ctl.sv
// per-port control, statistics, trunking, mirroring and rate limiting
module spc_port_ctl
  import spc_pkg::*;
#(
  parameter int NP      = 8,       // number of ports, at most 16
  parameter int NG      = 4,       // trunk groups
  parameter int CW      = 32,      // statistics counter width
  parameter int RW      = 16,      // rate value width
  parameter int WIN_LEN = WIN_CYC  // rate window in cycles
) (
  input  wire logic                ref_clk,         // 20 MHz clock
  input  wire logic                reset,           // sync, high
  input  wire logic [AW-1:0]       s_axi_awaddr,    // write address
  input  wire logic                s_axi_awvalid,   // write addr valid
  output logic                     s_axi_awready,   // write addr ready
  input  wire logic [31:0]         s_axi_wdata,     // write data
  input  wire logic [3:0]          s_axi_wstrb,     // byte enables
  input  wire logic                s_axi_wvalid,    // write data valid
  output logic                     s_axi_wready,    // write data ready
  output logic [1:0]               s_axi_bresp,     // write response
  output logic                     s_axi_bvalid,    // response valid
  input  wire logic                s_axi_bready,    // response ready
  input  wire logic [AW-1:0]       s_axi_araddr,    // read address
  input  wire logic                s_axi_arvalid,   // read addr valid
  output logic                     s_axi_arready,   // read addr ready
  output logic [31:0]              s_axi_rdata,     // read data
  output logic [1:0]               s_axi_rresp,     // read response
  output logic                     s_axi_rvalid,    // read valid
  input  wire logic                s_axi_rready,    // read ready
  input  wire logic [NP-1:0]       linkUp,          // phy link status
  input  wire logic [NP-1:0][1:0]  negSpeed,        // negotiated speed
  input  wire logic [NP-1:0]       negDuplex,       // negotiated full
  input  wire logic [15:0]         partnerSysPri,   // partner priority
  input  wire logic [NP-1:0]       partnerLacpAct,  // partner active
  input  wire logic [NP-1:0]       lacpPduRx,       // protocol pkt in
  input  wire logic [NP-1:0]       rxFrame,         // frame received
  input  wire logic [NP-1:0]       rxBad,           // frame malformed
  input  wire logic [NP-1:0]       rxBcast,         // broadcast dest
  input  wire logic [NP-1:0]       rxMcast,         // multicast dest
  input  wire logic [NP-1:0]       rxFlood,         // unknown unicast
  input  wire logic [NP-1:0]       rxSrcKnown,      // src in table
  input  wire logic [NP-1:0]       rxOverrun,       // rx buffer full
  input  wire logic [NP-1:0]       txDone,          // frame sent
  input  wire logic [NP-1:0]       txBad,           // sent malformed
  input  wire logic [NP-1:0]       txAbort,         // send aborted
  input  wire logic [NP-1:0]       txColl,          // collision seen
  output logic [NP-1:0]            portEn,          // rx/tx allowed
  output logic [NP-1:0]            anegEn,          // run negotiation
  output logic [NP-1:0][1:0]       speedEff,        // speed in use
  output logic [NP-1:0]            duplexEff,       // full duplex
  output logic [NP-1:0]            rxAccept,        // frame forwarded
  output logic [NP-1:0]            rxDrop,          // frame dropped
  output logic [NP-1:0]            txAllow,         // may transmit
  output logic [NP-1:0]            pauseSend,       // send pause pulse
  output logic [15:0]              pauseQuanta,     // pause length
  output logic [NP-1:0]            lacpTxAuto,      // may send unasked
  output logic [NP-1:0]            lacpTxReply,     // send answer pulse
  output logic [NP-1:0]            aggActive,       // in aggregate
  output logic [NP-1:0]            aggStandby,      // standby member
  output logic                     actSystem,       // we lead protocol
  output logic [NP-1:0]            mirRxHit,        // copy rx frame
  output logic [NP-1:0]            mirTxHit,        // copy tx frame
  output logic [7:0]               mirRxPort,       // rx mirror dest
  output logic [7:0]               mirTxPort        // tx mirror dest
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [NP-1:0][NCNT-1:0][CW-1:0] cnt;
    logic [NP-1:0][PC_W-1:0]         ctl;
    logic [NP-1:0][RW-1:0]           iRate;
    logic [NP-1:0][RW-1:0]           eRate;
    logic [NP-1:0][RW-1:0]           iCnt;
    logic [NP-1:0][RW-1:0]           eCnt;
    logic [NG-1:0][NP-1:0]           tMem;
    logic [NG-1:0]                   tLacp;
    logic [NG-1:0][2:0]              tWork;
    logic [31:0]                     win;
    logic [15:0]                     sysPri;
    logic [15:0]                     pauseQ;
    logic [7:0]                      mirRx;
    logic [7:0]                      mirTx;
    logic [NP-1:0]                   pause;
    logic [NP-1:0]                   reply;
    logic                            bValid;
    logic [1:0]                      bResp;
    logic                            rValid;
    logic [1:0]                      rResp;
    logic [31:0]                     rData;
  } spc_state_t;

  spc_state_t              s_r;
  spc_state_t              s_nxt;
  logic [NP-1:0][31:0]     ctlView;
  logic [NP-1:0]           upMask;
  logic [NP-1:0]           clsHit;
  logic [NP-1:0]           rxGood;
  logic [NP-1:0]           rxBlock;
  logic                    wrFire;
  logic                    rdFire;
  logic                    tick;

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [31:0] wMerge(input logic [31:0] o,
                                         input logic [31:0] n,
                                         input logic [3:0]  st);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (st[b]) r[8*b+:8] = n[8*b+:8];
    end
    return r;
  endfunction : wMerge

  // set bits of m below position p
  function automatic logic [3:0] rankOf(input logic [NP-1:0] m,
                                        input int p);
    logic [3:0] n;
    n = '0;
    for (int i = 0; i < NP; i++) begin
      if (i < p && m[i]) n = n + 4'h1;
    end
    return n;
  endfunction : rankOf

  function automatic logic clsMatch(input logic [1:0] c, input int p);
    logic r;
    case (c)
      2'h0:    r = 1'b1;
      2'h1:    r = rxBcast[p] | rxMcast[p] | rxFlood[p];
      2'h2:    r = rxBcast[p] | rxMcast[p];
      default: r = rxBcast[p];
    endcase
    return r;
  endfunction : clsMatch

  // {standby, active} of a port over all groups
  function automatic logic [1:0] aggOf(input int p);
    logic [1:0] r;
    logic [3:0] k;
    r = '0;
    for (int g = 0; g < NG; g++) begin
      if (s_r.tMem[g][p] && upMask[p]) begin
        k = rankOf(s_r.tMem[g] & upMask, p);
        if (!s_r.tLacp[g]) r[0] = 1'b1;
        else if (k >= {1'b0, s_r.tWork[g]}) r[1] = 1'b1;
        else if (s_r.ctl[p][PC_LACT] | partnerLacpAct[p])
          r[0] = 1'b1;
      end
    end
    return r;
  endfunction : aggOf

  function automatic logic [32:0] rdReg(input logic [AW-1:0] a);
    logic [32:0] r;
    int pi;
    int ci;
    r = '0;
    pi = int'(a[9:6]);
    ci = int'(a[5:2]);
    if (a == A_CLR) r = {1'b1, 32'h0000_0000};
    if (a == A_SYSPRI) r = {1'b1, 16'h0000, s_r.sysPri};
    if (a == A_MIR) r = {1'b1, 16'h0000, s_r.mirTx, s_r.mirRx};
    if (a == A_PAUSEQ) r = {1'b1, 16'h0000, s_r.pauseQ};
    if (a == A_STAT) r = {1'b1, 31'h0, actSystem};
    for (int g = 0; g < NG; g++) begin
      if (a == A_TRUNK + AW'(4 * g))
        r = {1'b1, 12'h000, s_r.tWork[g], s_r.tLacp[g],
             16'(s_r.tMem[g])};
    end
    for (int p = 0; p < NP; p++) begin
      if (a == A_PORT + AW'(4 * p)) r = {1'b1, ctlView[p]};
      if (a == A_RATE + AW'(4 * p))
        r = {1'b1, s_r.eRate[p], s_r.iRate[p]};
    end
    if (a[11] && pi < NP && ci < NCNT && a[1:0] == 2'h0)
      r = {1'b1, 32'(s_r.cnt[pi][ci])};
    return r;
  endfunction : rdReg

  // ****************************************************************
  // per-port decisions
  // ****************************************************************
  genvar gp;
  generate
    for (gp = 0; gp < NP; gp++) begin : g_port
      assign portEn[gp]    = s_r.ctl[gp][PC_EN];
      assign anegEn[gp]    = s_r.ctl[gp][PC_ANEG];
      assign speedEff[gp]  = s_r.ctl[gp][PC_ANEG] ? negSpeed[gp]
                           : s_r.ctl[gp][PC_SPD+:2];
      assign duplexEff[gp] = s_r.ctl[gp][PC_ANEG] ? negDuplex[gp]
                           : s_r.ctl[gp][PC_DUP];
      assign ctlView[gp]   = {19'h00000, linkUp[gp],
                              s_r.ctl[gp][PC_W-1:PC_DUP+1],
                              duplexEff[gp], speedEff[gp],
                              s_r.ctl[gp][1:0]};
      // half-duplex links are kept out of any aggregate
      assign upMask[gp]  = linkUp[gp] & portEn[gp]
                         & duplexEff[gp];
      assign clsHit[gp]  = clsMatch(s_r.ctl[gp][PC_CLS+:2], gp);
      assign rxGood[gp]  = rxFrame[gp] & portEn[gp] & ~rxBad[gp];
      assign rxBlock[gp] = (s_r.ctl[gp][PC_SEC] & ~rxSrcKnown[gp])
                         | (~s_r.ctl[gp][PC_FC] & rxOverrun[gp])
                         | (s_r.iRate[gp] != '0 & clsHit[gp]
                            & s_r.iCnt[gp] >= s_r.iRate[gp]);
      assign rxAccept[gp] = rxGood[gp] & ~rxBlock[gp];
      assign rxDrop[gp]   = rxGood[gp] & rxBlock[gp];
      assign txAllow[gp]  = portEn[gp] & (s_r.eRate[gp] == '0
                          | s_r.eCnt[gp] < s_r.eRate[gp]);
      assign {aggStandby[gp], aggActive[gp]} = aggOf(gp);
      assign lacpTxAuto[gp] = aggActive[gp] | aggStandby[gp]
                            ? s_r.ctl[gp][PC_LACT] : 1'b0;
      assign mirRxHit[gp] = rxAccept[gp] & s_r.ctl[gp][PC_RXM];
      assign mirTxHit[gp] = txDone[gp] & s_r.ctl[gp][PC_TXM];
    end
  endgenerate

  assign actSystem     = s_r.sysPri < partnerSysPri;
  assign pauseSend     = s_r.pause;
  assign lacpTxReply   = s_r.reply;
  assign pauseQuanta   = s_r.pauseQ;
  assign mirRxPort     = s_r.mirRx;
  assign mirTxPort     = s_r.mirTx;
  assign tick          = s_r.win == 32'(WIN_LEN - 1);
  // address and data are taken together so no write is half held
  assign wrFire        = s_axi_awvalid & s_axi_wvalid & ~s_r.bValid;
  assign s_axi_awready = s_axi_wvalid & ~s_r.bValid;
  assign s_axi_wready  = s_axi_awvalid & ~s_r.bValid;
  assign s_axi_bvalid  = s_r.bValid;
  assign s_axi_bresp   = s_r.bResp;
  assign rdFire        = s_axi_arvalid & ~s_r.rValid;
  assign s_axi_arready = ~s_r.rValid;
  assign s_axi_rvalid  = s_r.rValid;
  assign s_axi_rresp   = s_r.rResp;
  assign s_axi_rdata   = s_r.rData;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    logic [NCNT-1:0] ev;
    logic [32:0]     rd;
    logic [31:0]     wv;
    logic            clr;
    logic [NP-1:0]   m;
    ev    = '0;
    rd    = rdReg(s_axi_awaddr);
    wv    = wMerge(rd[31:0], s_axi_wdata, s_axi_wstrb);
    clr   = wrFire & s_axi_awaddr == A_CLR & wv[CLR_BIT];
    m     = '0;
    s_nxt = s_r;
    s_nxt.win   = tick ? 32'h0000_0000 : s_r.win + 32'h0000_0001;
    s_nxt.pause = '0;
    s_nxt.reply = '0;
    for (int p = 0; p < NP; p++) begin
      ev         = '0;
      ev[C_TXG]  = txDone[p] & ~txBad[p];
      ev[C_TXB]  = txDone[p] & txBad[p];
      ev[C_TXA]  = txAbort[p];
      ev[C_COL]  = txColl[p];
      ev[C_RXG]  = rxGood[p];
      ev[C_RXB]  = rxFrame[p] & portEn[p] & rxBad[p];
      ev[C_DRP]  = rxDrop[p];
      ev[C_BC]   = rxGood[p] & rxBcast[p];
      ev[C_MC]   = rxGood[p] & rxMcast[p];
      for (int c = 0; c < NCNT; c++) begin
        // an event in the clearing cycle still counts
        s_nxt.cnt[p][c] = (clr ? '0 : s_r.cnt[p][c])
                        + CW'(ev[c]);
      end
      s_nxt.iCnt[p] = (tick ? '0 : s_r.iCnt[p])
                    + RW'(rxAccept[p] & clsHit[p]);
      s_nxt.eCnt[p] = (tick ? '0 : s_r.eCnt[p])
                    + RW'(txDone[p]);
      s_nxt.pause[p] = rxGood[p] & s_r.ctl[p][PC_FC]
                     & rxOverrun[p];
      s_nxt.reply[p] = lacpPduRx[p] & ~s_r.ctl[p][PC_LACT]
                     & (aggActive[p] | aggStandby[p]);
    end
    if (s_r.bValid && s_axi_bready) s_nxt.bValid = 1'b0;
    if (wrFire) begin
      s_nxt.bValid = 1'b1;
      s_nxt.bResp  = rd[32] ? RESP_OK : RESP_ERR;
      if (s_axi_awaddr == A_SYSPRI) s_nxt.sysPri = wv[15:0];
      if (s_axi_awaddr == A_PAUSEQ) s_nxt.pauseQ = wv[15:0];
      if (s_axi_awaddr == A_MIR) begin
        s_nxt.mirRx = wv[7:0];
        s_nxt.mirTx = wv[15:8];
      end
      for (int g = 0; g < NG; g++) begin
        if (s_axi_awaddr == A_TRUNK + AW'(4 * g)) begin
          m = wv[NP-1:0];
          for (int p = 0; p < NP; p++) begin
            if (rankOf(wv[NP-1:0], p) >= MAX_MEM) m[p] = 1'b0;
          end
          s_nxt.tMem[g]  = m;
          s_nxt.tLacp[g] = wv[TR_LACP];
          s_nxt.tWork[g] = wv[TR_WORK+:3] > 3'(MAX_MEM)
                         ? 3'(MAX_MEM) : wv[TR_WORK+:3];
        end
      end
      for (int p = 0; p < NP; p++) begin
        if (s_axi_awaddr == A_PORT + AW'(4 * p)) begin
          s_nxt.ctl[p] = wv[PC_W-1:0];
          // negotiated fields stay unwritable in automatic mode
          if (wv[PC_ANEG]) begin
            s_nxt.ctl[p][PC_SPD+:2] = s_r.ctl[p][PC_SPD+:2];
            s_nxt.ctl[p][PC_DUP]    = s_r.ctl[p][PC_DUP];
          end
        end
        if (s_axi_awaddr == A_RATE + AW'(4 * p)) begin
          s_nxt.iRate[p] = wv[RW-1:0];
          s_nxt.eRate[p] = wv[16+:RW];
        end
      end
    end
    if (s_r.rValid && s_axi_rready) s_nxt.rValid = 1'b0;
    if (rdFire) begin
      rd           = rdReg(s_axi_araddr);
      s_nxt.rValid = 1'b1;
      s_nxt.rData  = rd[31:0];
      s_nxt.rResp  = rd[32] ? RESP_OK : RESP_ERR;
    end
    if (reset) begin
      s_nxt        = '0;
      s_nxt.sysPri = SYSPRI_RST;
      s_nxt.pauseQ = PAUSEQ_RST;
      for (int p = 0; p < NP; p++) s_nxt.ctl[p] = PORT_CTL_RST;
    end
  end

  always_ff @(posedge ref_clk) begin
    s_r <= s_nxt;
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_fcOverrun;
    rxGood[0] & s_r.ctl[0][PC_FC] & rxOverrun[0];
  endsequence
  property p_disRx;
    ~portEn[0] |-> ~rxAccept[0] & ~rxDrop[0] & ~txAllow[0];
  endproperty
  a_disRx: assert property (p_disRx) else $error("disabled port moved");
  property p_clear;
    wrFire & s_axi_awaddr == A_CLR & s_axi_wdata[0] & s_axi_wstrb[0]
      |=> s_r.cnt[0][C_TXG] == CW'($past(txDone[0] & ~txBad[0]));
  endproperty
  a_clear: assert property (p_clear) else $error("clear missed");
  property p_pause;
    s_fcOverrun |=> pauseSend[0] ##1 ~pauseSend[0] | $past(rxGood[0]);
  endproperty
  a_pause: assert property (p_pause) else $error("no pause sent");
  property p_drop;
    rxGood[0] & ~s_r.ctl[0][PC_FC] & rxOverrun[0] |-> rxDrop[0];
  endproperty
  a_drop: assert property (p_drop) else $error("overrun not dropped");
  property p_sec;
    s_r.ctl[0][PC_SEC] & ~rxSrcKnown[0] |-> ~rxAccept[0];
  endproperty
  a_sec: assert property (p_sec) else $error("unknown source passed");
  property p_noLimit;
    portEn[0] & s_r.eRate[0] == '0 |-> txAllow[0];
  endproperty
  a_noLimit: assert property (p_noLimit) else $error("zero rate held");
  // stored forced values must survive a write made in automatic mode
  property p_aneg;
    wrFire & s_axi_awaddr == A_PORT & s_axi_wdata[PC_ANEG] & s_axi_wstrb[0]
      |=> s_r.ctl[0][PC_DUP:PC_SPD] == $past(s_r.ctl[0][PC_DUP:PC_SPD]);
  endproperty
  a_aneg: assert property (p_aneg) else $error("aneg write landed");
  property p_work;
    s_r.tLacp[0] |-> $countones(aggActive & s_r.tMem[0])
                     <= int'(s_r.tWork[0]);
  endproperty
  a_work: assert property (p_work) else $error("too many working");
  property p_passive;
    s_r.tLacp[0] & s_r.tMem[0][0] & ~s_r.ctl[0][PC_LACT]
      & ~partnerLacpAct[0] |-> ~aggActive[0];
  endproperty
  a_passive: assert property (p_passive) else $error("passive trunk");
  property p_gather;
    rxGood[0] & ~rxBad[0] |=> s_r.cnt[0][C_RXG] != $past(s_r.cnt[0][C_RXG])
                            | $past(wrFire & s_axi_awaddr == A_CLR);
  endproperty
  a_gather: assert property (p_gather) else $error("rx good lost");
endmodule : spc_port_ctl

// File: verilog/spc_pkg.sv
// constants shared by the switch port control and statistics block
// How it works
// - a disabled port neither receives nor transmits any frame
// - per port, transmitted bad frames are counted
// - per port, received bad frames are counted
// - per port, good transmitted and good received frames are counted apart
// - aborts, collisions, drops, broadcast and multicast receptions are counted
// - the clear command zeroes every statistics counter
// - automatic mode uses negotiated speed and duplex, forced mode configured
// - speed and duplex are read-only while automatic, writable when forced
// - with flow control on, an overrun receiver sends a pause frame
// - with flow control off, an overrun receiver drops the frame
// - port security blocks frames whose source address is not known
// - four trunk groups, each of at most four member ports
// - aggregated member links run in full duplex on both ends
// - the lower system priority value is the active protocol system
// - protocol trunk members past the working count wait on standby
// - a static trunk has every up, enabled, full-duplex member port active
// - a static trunk member joins without any handshake
// - active ports send protocol packets unasked; passive ones only answer
// - a dynamic trunk needs at least one active end
// - mirroring copies chosen receive or transmit traffic to a destination
// - one destination for both directions, or one per direction
// - ingress limits one of four frame classes; egress limits all frames
package spc_pkg;
  // ****************************************************************
  // register byte addresses
  // ****************************************************************
  localparam int           AW       = 12;
  localparam logic [11:0]  A_CLR    = 12'h000;
  localparam logic [11:0]  A_SYSPRI = 12'h004;
  localparam logic [11:0]  A_MIR    = 12'h008;
  localparam logic [11:0]  A_PAUSEQ = 12'h00C;
  localparam logic [11:0]  A_STAT   = 12'h010;
  localparam logic [11:0]  A_TRUNK  = 12'h020;
  localparam logic [11:0]  A_PORT   = 12'h100;
  localparam logic [11:0]  A_RATE   = 12'h200;
  localparam logic [11:0]  A_CNT    = 12'h800;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PC_EN   = 0;
  localparam int PC_ANEG = 1;
  localparam int PC_SPD  = 2;
  localparam int PC_DUP  = 4;
  localparam int PC_FC   = 5;
  localparam int PC_SEC  = 6;
  localparam int PC_LACT = 7;
  localparam int PC_RXM  = 8;
  localparam int PC_TXM  = 9;
  localparam int PC_CLS  = 10;
  localparam int PC_W    = 12;
  localparam int TR_LACP = 16;
  localparam int TR_WORK = 17;
  localparam int CLR_BIT = 0;
  // ****************************************************************
  // counters, reset values, timing
  // ****************************************************************
  localparam int C_TXG = 0;
  localparam int C_TXB = 1;
  localparam int C_RXG = 2;
  localparam int C_RXB = 3;
  localparam int C_TXA = 4;
  localparam int C_COL = 5;
  localparam int C_DRP = 6;
  localparam int C_BC  = 7;
  localparam int C_MC  = 8;
  localparam int NCNT  = 9;
  localparam logic [11:0] PORT_CTL_RST = 12'h013;
  localparam logic [15:0] SYSPRI_RST   = 16'h8000;
  localparam logic [15:0] PAUSEQ_RST   = 16'hFFFF;
  localparam logic [3:0]  MAX_MEM      = 4'h4;
  localparam logic [1:0]  RESP_OK      = 2'h0;
  localparam logic [1:0]  RESP_ERR     = 2'h2;
  localparam int CLK_NS  = 50;
  localparam int WIN_US  = 1000;
  localparam int WIN_CYC = WIN_US * 1000 / CLK_NS;
endpackage : spc_pkg

// File: testbench/spc_link_partner.sv
// link partner model: link, negotiation result, protocol packets
module spc_link_partner #(
  parameter int NP = 8  // number of ports
) (
  input  wire logic           ref_clk,        // 20 MHz clock
  input  wire logic           pduReq,         // partner answers next cycle
  output logic [NP-1:0]       linkUp,         // link status
  output logic [NP-1:0][1:0]  negSpeed,       // agreed speed
  output logic [NP-1:0]       negDuplex,      // agreed duplex
  output logic [15:0]         partnerSysPri,  // partner priority
  output logic [NP-1:0]       partnerLacpAct, // partner is active
  output logic [NP-1:0]       lacpPduRx       // packet pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  assign linkUp = '1;
  assign negSpeed = {NP{2'h2}};
  assign negDuplex = '1;
  assign partnerSysPri = 16'h4000;
  // passive partner: packets only when the bench asks
  assign partnerLacpAct = '0;
  always_ff @(posedge ref_clk) begin
    lacpPduRx <= {NP{pduReq}};
  end
endmodule : spc_link_partner

// File: testbench/switch_port_control_stats_test.sv
// self-checking bench for the port control and statistics block
module switch_port_control_stats_test;
  timeunit 1ns;
  timeprecision 1ns;
  import spc_pkg::*;
  logic ref_clk = 0, reset = 1, pduReq = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, actSystem, a, dr, ps;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [7:0] rxFrame = 0, rxBad = 0, rxBcast = 0, rxMcast = 0;
  logic [7:0] rxFlood = 0, rxSrcKnown = 8'hFF, rxOverrun = 0;
  logic [7:0] txDone = 0, txBad = 0, txAbort = 0, txColl = 0;
  logic [7:0] linkUp, negDuplex, partnerLacpAct, lacpPduRx;
  logic [7:0] portEn, anegEn, duplexEff, rxAccept, rxDrop, txAllow;
  logic [7:0] pauseSend, lacpTxAuto, lacpTxReply, aggActive;
  logic [7:0] aggStandby, mirRxHit, mirTxHit, mirRxPort, mirTxPort;
  logic [7:0][1:0] negSpeed, speedEff;
  logic [15:0] partnerSysPri, pauseQuanta;
  int error_cnt = 0, tests_run = 0;
  int ec[9] = '{1, 1, 3, 1, 1, 1, 0, 1, 1};
  spc_port_ctl #(.WIN_LEN(16)) u_spc_port_ctl (.*);
  spc_link_partner u_spc_link_partner (.*);
  always #25 ref_clk = ~ref_clk;
  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] ad, input logic [31:0] dt);
    s_axi_awaddr <= ad;
    s_axi_wdata <= dt;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do @(posedge ref_clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] ad);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge ref_clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : rd
  // one frame on port 0: verdict same cycle, pause one cycle later
  task automatic rx();
    rxFrame <= 8'h01;
    @(posedge ref_clk);
    a = rxAccept[0];
    dr = rxDrop[0];
    rxFrame <= 8'h00;
    @(posedge ref_clk);
    ps = pauseSend[0];
  endtask : rx
  task automatic t_count();
    rx();
    rxBad <= 8'h01;
    rx();
    rxBad <= 8'h00;
    rxBcast <= 8'h01;
    rx();
    rxBcast <= 8'h00;
    rxMcast <= 8'h01;
    rx();
    rxMcast <= 8'h00;
    txDone <= 8'h01;
    @(posedge ref_clk);
    txBad <= 8'h01;
    @(posedge ref_clk);
    {txDone, txBad, txAbort, txColl} <= {16'h0000, 16'h0101};
    @(posedge ref_clk);
    {txAbort, txColl} <= 16'h0000;
    for (int c = 0; c < NCNT; c++) begin
      rd(A_CNT + 12'(c * 4));
      chk(d, 32'(ec[c]));
    end
    wr(A_CLR, 32'h0000_0001);
    for (int c = 0; c < NCNT; c++) begin
      rd(A_CNT + 12'(c * 4));
      chk(d, 32'h0);
    end
  endtask : t_count
  task automatic t_port();
    chk({31'h0, speedEff[0] === negSpeed[0]}, 32'h1);
    wr(A_PORT, 32'h0000_000D);
    chk({27'h0, portEn[0], anegEn[0], duplexEff[0], speedEff[0]},
        32'h0000_0013);
    wr(A_PORT, 32'h0000_0012);
    rx();
    chk({31'h0, a | txAllow[0]}, 32'h0);
    wr(A_PORT, 32'h0000_0033);
    rxOverrun <= 8'h01;
    rx();
    chk({30'h0, a, ps}, 32'h3);
    wr(A_PORT, 32'h0000_0013);
    rx();
    chk({30'h0, dr, ps}, 32'h2);
    rxOverrun <= 8'h00;
    rxSrcKnown <= 8'h00;
    wr(A_PORT, 32'h0000_0053);
    rx();
    chk({30'h0, a, dr}, 32'h1);
    rd(A_CNT + 12'(C_DRP * 4));
    chk(d, 32'h2);
  endtask : t_port
  task automatic t_prio();
    wr(A_SYSPRI, 32'h0000_3FFF);
    rd(A_STAT);
    chk(d & 32'h1, 32'h1);
    wr(A_SYSPRI, 32'h0000_4001);
    rd(A_STAT);
    chk(d & 32'h1, 32'h0);
  endtask : t_prio
  // ports 0..3 in a protocol group of two working, 4 and 5 static
  task automatic t_trunk();
    rxSrcKnown <= 8'hFF;
    wr(A_TRUNK, 32'h0005_001F);
    rd(A_TRUNK);
    chk(d, 32'h0005_000F);
    chk({16'h0, aggStandby, aggActive}, 32'h0000_0C00);
    wr(A_PORT, 32'h0000_0393);
    wr(A_PORT + 12'h004, 32'h0000_0093);
    pduReq <= 1'b1;
    @(posedge ref_clk);
    pduReq <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk({24'h0, lacpTxReply}, 32'h0000_000C);
    wr(A_TRUNK + 12'h004, 32'h0000_0030);
    chk({8'h0, aggStandby, aggActive, lacpTxAuto},
        32'h000C_3303);
    wr(A_PORT + 12'h014, 32'h0000_0001);
    chk({24'h0, aggActive}, 32'h0000_0013);
    wr(A_MIR, 32'h0000_0605);
    wr(A_RATE, 32'h0001_0001);
    {rxFrame, txDone} <= 16'h0101;
    @(posedge ref_clk);
    chk({8'h0, mirTxPort, mirRxPort, 6'h0, mirRxHit[0], mirTxHit[0]},
        32'h0006_0503);
    {rxFrame, txDone} <= 16'h0000;
    @(posedge ref_clk);
    chk({31'h0, txAllow[0]}, 32'h0);
    wr(A_PORT, 32'h0000_0F93);
    rx();
    rx();
    chk({31'h0, a}, 32'h1);
    wr(A_RATE, 32'h0);
    chk({31'h0, txAllow[0]}, 32'h1);
  endtask : t_trunk
  initial begin
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(A_PORT);
    chk(d, 32'h0000_101B);
    chk({16'h0, pauseQuanta}, {16'h0, PAUSEQ_RST});
    t_count();
    t_port();
    t_prio();
    t_trunk();
    wr(12'h7F0, 32'h0);
    chk({30'h0, r}, {30'h0, RESP_ERR});
    end_of_test();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    end_of_test();
  end
endmodule : switch_port_control_stats_test
